//--- rtl/ppcmf_pad_ctrl.v
`timescale 1ns/1ps
`include "ppcmf_defs.vh"

// Notes on behaviour
// - Write protect on blocks writes to drive, pull-up, filter-off and peripheral select registers.
// - Multi-drive disable write of 1 makes that line push-pull; 0 ignored.
// - Multi-drive status reads 0 for push-pull, 1 for low-only drive.
// - Pull-up disable write of 1 turns that pull-up off; 0 ignored.
// - Pull-up enable write of 1 turns that pull-up on; 0 ignored.
// - Pull-up status reads 0 when enabled, 1 when disabled.
// - Select bits high,low: 00 A, 01 B, 10 C, 11 D.
// - Glitch-select write of 1 puts that line's filter in glitch mode.
// - Debounce-select write of 1 puts that line's filter in debounce mode.
// - Filter select status reads 0 for glitch, 1 for debounce.
// - Divider is bits 13..0; divided period is (value+1)*2 slow periods.
// - Filtering acts only while the line's filter is on; status shows it.
module ppcmf_pad_ctrl #(
  parameter LINES = 32,
  parameter DIV_WIDTH = `PPCMF_DIV_WIDTH
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Slow clock pin for debouncing
  input wire slck,
  // Classic Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Pads
  input wire [LINES-1:0] padIn,
  output reg [LINES-1:0] padOut,
  output reg [LINES-1:0] padOe,
  output wire [LINES-1:0] pullupOn,
  // Peripheral functions A to D
  input wire [LINES-1:0] funcOutA,
  input wire [LINES-1:0] funcOutB,
  input wire [LINES-1:0] funcOutC,
  input wire [LINES-1:0] funcOutD,
  input wire [LINES-1:0] funcOeA,
  input wire [LINES-1:0] funcOeB,
  input wire [LINES-1:0] funcOeC,
  input wire [LINES-1:0] funcOeD,
  output reg [LINES-1:0] funcIn
);

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Byte lanes turned into a bit mask
  function [31:0] laneMask;
    input [3:0] sel;
    begin
      laneMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // Set bits where written ones, clear where cleared ones
  function [31:0] setClear;
    input [31:0] cur;
    input [31:0] setBits;
    input [31:0] clrBits;
    begin
      setClear = (cur | setBits) & ~clrBits;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // State

  reg [LINES-1:0] multidrive;
  reg [LINES-1:0] pullupOff;
  reg [LINES-1:0] selLow;
  reg [LINES-1:0] selHigh;
  reg [LINES-1:0] debounceMode;
  reg [LINES-1:0] filterOn;
  reg [DIV_WIDTH-1:0] divider;
  reg writeProtect;
  reg [LINES-1:0] padMeta;
  reg [LINES-1:0] padSync;
  reg [LINES-1:0] glitchPrev;
  reg [LINES-1:0] glitchOut;
  reg [31:0] next_rdata;
  reg [LINES-1:0] next_out;
  reg [LINES-1:0] next_oe;
  reg [1:0] funcSel;
  integer i;

  wire access;
  wire doWrite;
  wire [31:0] wmask;
  wire [31:0] wset;
  wire [LINES-1:0] lineSet;
  wire unlocked;
  wire halfTick;
  wire [LINES-1:0] debounced;

  ////////////////////////////////////////////////////////////////
  // Bus handshake: ack one cycle after the request, write at the ack edge

  assign access = wb_cyc_i & wb_stb_i;
  assign doWrite = access & wb_we_i & wb_ack_o;
  assign wmask = laneMask(wb_sel_i);
  assign wset = wb_dat_i & wmask;
  assign lineSet = wset[LINES-1:0];
  assign unlocked = ~writeProtect;

  // Ack pulses for one cycle per request, then drops
  always @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access & ~wb_ack_o;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero but are still acked

  always @* begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      `PPCMF_ADR_FILTER_STATUS: next_rdata[LINES-1:0] = filterOn;
      `PPCMF_ADR_MULTIDRIVE_STATUS: next_rdata[LINES-1:0] = multidrive;
      `PPCMF_ADR_PULLUP_STATUS: next_rdata[LINES-1:0] = pullupOff;
      `PPCMF_ADR_FILTER_CLOCK_SELECT_STATUS: next_rdata[LINES-1:0] = debounceMode;
      `PPCMF_ADR_DEBOUNCE_CLOCK_DIVIDER: next_rdata[`PPCMF_DIV_MSB:0] = divider;
      `PPCMF_ADR_WRITE_PROTECT: next_rdata[`PPCMF_WP_BIT] = writeProtect;
      `PPCMF_ADR_PERIPHERAL_SELECT_LOW: next_rdata[LINES-1:0] = selLow;
      `PPCMF_ADR_PERIPHERAL_SELECT_HIGH: next_rdata[LINES-1:0] = selHigh;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data captured as ack rises and held while it is high
  always @(posedge mclk) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (access & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Configuration registers. Set/clear pairs touch only written ones,
  // so two drivers in software need no read-modify-write.

  always @(posedge mclk) begin
    if (rst) begin
      multidrive <= `PPCMF_RST_LINES;
      pullupOff <= `PPCMF_RST_LINES;
      selLow <= `PPCMF_RST_LINES;
      selHigh <= `PPCMF_RST_LINES;
      debounceMode <= `PPCMF_RST_LINES;
      filterOn <= `PPCMF_RST_LINES;
      divider <= `PPCMF_RST_DIV;
      writeProtect <= `PPCMF_RST_WP;
    end else if (doWrite) begin
      case (wb_adr_i)
        `PPCMF_ADR_FILTER_ON: begin
          filterOn <= setClear(filterOn, lineSet, {LINES{1'b0}});
        end
        `PPCMF_ADR_FILTER_OFF: begin
          if (unlocked) begin
            filterOn <= setClear(filterOn, {LINES{1'b0}}, lineSet);
          end
        end
        `PPCMF_ADR_MULTIDRIVE_ENABLE: begin
          if (unlocked) begin
            multidrive <= setClear(multidrive, lineSet, {LINES{1'b0}});
          end
        end
        `PPCMF_ADR_MULTIDRIVE_DISABLE: begin
          if (unlocked) begin
            multidrive <= setClear(multidrive, {LINES{1'b0}}, lineSet);
          end
        end
        `PPCMF_ADR_PULLUP_DISABLE: begin
          if (unlocked) begin
            pullupOff <= setClear(pullupOff, lineSet, {LINES{1'b0}});
          end
        end
        `PPCMF_ADR_PULLUP_ENABLE: begin
          if (unlocked) begin
            pullupOff <= setClear(pullupOff, {LINES{1'b0}}, lineSet);
          end
        end
        `PPCMF_ADR_FILTER_CLOCK_GLITCH_SELECT: begin
          debounceMode <= setClear(debounceMode, {LINES{1'b0}}, lineSet);
        end
        `PPCMF_ADR_FILTER_CLOCK_DEBOUNCE_SELECT: begin
          debounceMode <= setClear(debounceMode, lineSet, {LINES{1'b0}});
        end
        `PPCMF_ADR_DEBOUNCE_CLOCK_DIVIDER: begin
          // Lanes merged so a byte write keeps the other byte
          divider <= (divider & ~wmask[`PPCMF_DIV_MSB:0]) |
                     wset[`PPCMF_DIV_MSB:0];
        end
        `PPCMF_ADR_WRITE_PROTECT: begin
          if (wb_sel_i[0]) begin
            writeProtect <= wb_dat_i[`PPCMF_WP_BIT];
          end
        end
        `PPCMF_ADR_PERIPHERAL_SELECT_LOW: begin
          if (unlocked) begin
            selLow <= (selLow & ~wmask[LINES-1:0]) | lineSet;
          end
        end
        `PPCMF_ADR_PERIPHERAL_SELECT_HIGH: begin
          if (unlocked) begin
            selHigh <= (selHigh & ~wmask[LINES-1:0]) | lineSet;
          end
        end
        default: begin
          writeProtect <= writeProtect;
        end
      endcase
    end
  end

  assign pullupOn = ~pullupOff;

  ////////////////////////////////////////////////////////////////
  // Output routing: function mux, then open-drain conversion.
  // An open-drain line never drives high, so a wired-AND bus is safe.

  always @* begin
    next_out = {LINES{1'b0}};
    next_oe = {LINES{1'b0}};
    funcSel = `PPCMF_FUNC_A;
    for (i = 0; i < LINES; i = i + 1) begin
      funcSel = {selHigh[i], selLow[i]};
      case (funcSel)
        `PPCMF_FUNC_A: begin
          next_out[i] = funcOutA[i];
          next_oe[i] = funcOeA[i];
        end
        `PPCMF_FUNC_B: begin
          next_out[i] = funcOutB[i];
          next_oe[i] = funcOeB[i];
        end
        `PPCMF_FUNC_C: begin
          next_out[i] = funcOutC[i];
          next_oe[i] = funcOeC[i];
        end
        default: begin
          next_out[i] = funcOutD[i];
          next_oe[i] = funcOeD[i];
        end
      endcase
      if (multidrive[i]) begin
        next_oe[i] = next_oe[i] & ~next_out[i];
        next_out[i] = 1'b0;
      end
    end
  end

  // Pad drive registered, one cycle behind the function outputs
  always @(posedge mclk) begin
    if (rst) begin
      padOut <= {LINES{1'b0}};
      padOe <= {LINES{1'b0}};
    end else begin
      padOut <= next_out;
      padOe <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Input path: synchronise, glitch filter, debounce, select

  always @(posedge mclk) begin
    if (rst) begin
      padMeta <= {LINES{1'b0}};
      padSync <= {LINES{1'b0}};
    end else begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  // Two matching samples needed; a one-sample glitch is dropped
  always @(posedge mclk) begin
    if (rst) begin
      glitchPrev <= {LINES{1'b0}};
      glitchOut <= {LINES{1'b0}};
    end else begin
      glitchPrev <= padSync;
      glitchOut <= (glitchOut & (padSync ^ glitchPrev)) |
                   (padSync & ~(padSync ^ glitchPrev));
    end
  end

  ppcmf_slow_div #(
    .DIV_WIDTH(DIV_WIDTH)
  ) ppcmf_slow_div_i (
    .mclk(mclk),
    .rst(rst),
    .slck(slck),
    .divider(divider),
    .halfTick(halfTick)
  );

  ppcmf_debounce #(
    .LINES(LINES)
  ) ppcmf_debounce_i (
    .mclk(mclk),
    .rst(rst),
    .halfTick(halfTick),
    .lineIn(padSync),
    .lineOut(debounced)
  );

  // Unfiltered lines see the synchronised pad directly
  always @(posedge mclk) begin
    if (rst) begin
      funcIn <= {LINES{1'b0}};
    end else begin
      funcIn <= (~filterOn & padSync) |
                (filterOn & ~debounceMode & glitchOut) |
                (filterOn & debounceMode & debounced);
    end
  end

endmodule

//--- rtl/ppcmf_defs.vh
`ifndef PPCMF_DEFS_VH
`define PPCMF_DEFS_VH

// Register byte addresses
`define PPCMF_ADR_FILTER_ON 32'h400e0e20
`define PPCMF_ADR_FILTER_OFF 32'h400e0e24
`define PPCMF_ADR_FILTER_STATUS 32'h400e0e28
`define PPCMF_ADR_MULTIDRIVE_ENABLE 32'h400e0e50
`define PPCMF_ADR_MULTIDRIVE_DISABLE 32'h400e0e54
`define PPCMF_ADR_MULTIDRIVE_STATUS 32'h400e0e58
`define PPCMF_ADR_PULLUP_DISABLE 32'h400e0e60
`define PPCMF_ADR_PULLUP_ENABLE 32'h400e0e64
`define PPCMF_ADR_PULLUP_STATUS 32'h400e0e68
`define PPCMF_ADR_FILTER_CLOCK_GLITCH_SELECT 32'h400e0e80
`define PPCMF_ADR_FILTER_CLOCK_DEBOUNCE_SELECT 32'h400e0e84
`define PPCMF_ADR_FILTER_CLOCK_SELECT_STATUS 32'h400e0e88
`define PPCMF_ADR_DEBOUNCE_CLOCK_DIVIDER 32'h400e0e8c
`define PPCMF_ADR_WRITE_PROTECT 32'h400e0ee4
`define PPCMF_ADR_PERIPHERAL_SELECT_LOW 32'h400e0ef0
`define PPCMF_ADR_PERIPHERAL_SELECT_HIGH 32'h400e0ef4

// Field positions
`define PPCMF_DIV_MSB 13
`define PPCMF_DIV_WIDTH 14
`define PPCMF_WP_BIT 0

// Reset values
`define PPCMF_RST_LINES 32'h00000000
`define PPCMF_RST_DIV 14'h0000
`define PPCMF_RST_WP 1'b0

// Function select codes, {high, low}
`define PPCMF_FUNC_A 2'h0
`define PPCMF_FUNC_B 2'h1
`define PPCMF_FUNC_C 2'h2
`define PPCMF_FUNC_D 2'h3

`endif

//--- rtl/ppcmf_slow_div.v
`timescale 1ns/1ps
`include "ppcmf_defs.vh"

module ppcmf_slow_div #(
  parameter DIV_WIDTH = `PPCMF_DIV_WIDTH
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Slow clock pin and divider setting
  input wire slck,
  input wire [DIV_WIDTH-1:0] divider,
  // One pulse per half period of the divided slow clock
  output reg halfTick
);

  reg slckMeta;
  reg slckSync;
  reg slckPrev;
  reg [DIV_WIDTH-1:0] count;
  wire slckRise;

  ////////////////////////////////////////////////////////////////
  // Two-stage synchroniser, edge found after the second stage
  always @(posedge mclk) begin
    if (rst) begin
      slckMeta <= 1'b0;
      slckSync <= 1'b0;
      slckPrev <= 1'b0;
    end else begin
      slckMeta <= slck;
      slckSync <= slckMeta;
      slckPrev <= slckSync;
    end
  end

  assign slckRise = slckSync & ~slckPrev;

  ////////////////////////////////////////////////////////////////
  // Half period is divider+1 slow edges, so full period is (div+1)*2
  always @(posedge mclk) begin
    if (rst) begin
      count <= {DIV_WIDTH{1'b0}};
      halfTick <= 1'b0;
    end else begin
      halfTick <= 1'b0;
      if (slckRise) begin
        if (count >= divider) begin
          count <= {DIV_WIDTH{1'b0}};
          halfTick <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule

//--- rtl/ppcmf_debounce.v
`timescale 1ns/1ps

module ppcmf_debounce #(
  parameter LINES = 32
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Sample strobe, one per half divided period
  input wire halfTick,
  // Synchronised line levels in, debounced levels out
  input wire [LINES-1:0] lineIn,
  output reg [LINES-1:0] lineOut
);

  reg [LINES-1:0] sample;

  ////////////////////////////////////////////////////////////////
  // A level passes only when two strobes in a row agree, so it must
  // have stood for at least half a divided period; shorter pulses vanish
  always @(posedge mclk) begin
    if (rst) begin
      sample <= {LINES{1'b0}};
      lineOut <= {LINES{1'b0}};
    end else if (halfTick) begin
      sample <= lineIn;
      lineOut <= (lineOut & ~(lineIn ~^ sample)) | (lineIn & (lineIn ~^ sample));
    end
  end

endmodule

//--- testbench/ppcmf_pad_ctrl_properties.sv
`timescale 1ns/1ps
`include "ppcmf_defs.vh"

module ppcmf_pad_ctrl_properties #(
  parameter LINES = 32
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Pull-up controls
  input wire [LINES-1:0] pullupOn
);
  reg protectOn;
  wire wrAck;
  wire rdAck;
  wire fullWr;
  //////////////////////////////////////////////////
  // Completed transfers, split by direction
  assign wrAck = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
  assign rdAck = wb_ack_o & wb_cyc_i & wb_stb_i & ~wb_we_i;
  assign fullWr = wrAck & ~protectOn & (wb_sel_i == 4'hf);
  // Shadow of the protect bit, so ignored writes can be told from lost ones
  always @(posedge mclk) begin
    if (rst) begin
      protectOn <= 1'b0;
    end else if (wrAck && wb_adr_i == `PPCMF_ADR_WRITE_PROTECT && wb_sel_i[0]) begin
      protectOn <= wb_dat_i[`PPCMF_WP_BIT];
    end
  end
  //////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence reqOpen;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  reqAnswer_a: assert property (reqOpen |=> ackPulse)
    else $error("ack did not follow request as a single pulse");
  ackCause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  pullupReset_a: assert property (disable iff (1'b0) rst |=> pullupOn == {LINES{1'b1}})
    else $error("pull-ups not on after reset");
  pullupHold_a: assert property ($changed(pullupOn) |-> $past(wrAck))
    else $error("pull-up changed without a write");
  pullupClear_a: assert property (fullWr && wb_adr_i == `PPCMF_ADR_PULLUP_DISABLE
    |=> pullupOn == $past(pullupOn & ~wb_dat_i[LINES-1:0]))
    else $error("pull-up disable write wrong");
  pullupSet_a: assert property (fullWr && wb_adr_i == `PPCMF_ADR_PULLUP_ENABLE
    |=> pullupOn == $past(pullupOn | wb_dat_i[LINES-1:0]))
    else $error("pull-up enable write wrong");
  protectHold_a: assert property (wrAck && protectOn && (wb_adr_i == `PPCMF_ADR_PULLUP_ENABLE
    || wb_adr_i == `PPCMF_ADR_PULLUP_DISABLE) |=> $stable(pullupOn))
    else $error("protected pull-up write took effect");
  statusPull_a: assert property (rdAck && wb_adr_i == `PPCMF_ADR_PULLUP_STATUS
    |-> wb_dat_o == ~pullupOn)
    else $error("pull-up status not inverse of pull-up");
endmodule

bind ppcmf_pad_ctrl ppcmf_pad_ctrl_properties #(.LINES(LINES)) ppcmf_pad_ctrl_properties_i (
  .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pullupOn(pullupOn));

//--- testbench/ppcmf_pad_model.sv
`timescale 1ns/1ps

module ppcmf_pad_model #(
  parameter LINES = 32
) (
  // Clock
  input wire mclk,
  // Controller pad side
  input wire [LINES-1:0] padOut,
  input wire [LINES-1:0] padOe,
  input wire [LINES-1:0] pullupOn,
  // Outside driver
  input wire [LINES-1:0] extLevel,
  input wire [LINES-1:0] extOe,
  // Resolved level
  output wire [LINES-1:0] padIn
);
  reg [LINES-1:0] floatPat = {LINES{1'b0}};
  // A pad nobody drives and no pull-up holds wanders, never a steady level
  always @(posedge mclk) begin
    floatPat <= ~floatPat;
  end
  // Controller wins, then outside driver, then pull-up, else floating
  assign padIn = (padOe & padOut) | (~padOe & extOe & extLevel)
    | (~padOe & ~extOe & (pullupOn | floatPat));
endmodule

//--- testbench/tb_pio_pad_config_mux_filter.sv
`timescale 1ns/1ps
`include "ppcmf_defs.vh"

module tb_pio_pad_config_mux_filter;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg slck = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [31:0] adr = 32'h00000000;
  reg [3:0] sel = 4'h0;
  reg [31:0] datW = 32'h00000000;
  reg [31:0] fOe = 32'hffffffff;
  reg [31:0] extLevel = 32'h00000000;
  reg [31:0] extOe = 32'h00000000;
  reg [31:0] rd;
  wire [31:0] datR, padIn, padOut, padOe, pullupOn, funcIn;
  wire ack;
  integer errors = 0;
  integer testsRun = 0;
  integer k;
  //////////////////////////////////////////////////
  // Each function leaves a different line undriven, so a swapped enable shows up
  ppcmf_pad_ctrl ppcmf_pad_ctrl_i (.mclk(mclk), .rst(rst), .slck(slck),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .pullupOn(pullupOn), .funcOutA(32'h11111111), .funcOutB(32'h22222222),
    .funcOutC(32'h44444444), .funcOutD(32'h88888888), .funcOeA(fOe & 32'hfffffffe),
    .funcOeB(fOe & 32'hfffffffd), .funcOeC(fOe & 32'hfffffffb),
    .funcOeD(fOe & 32'hfffffff7), .funcIn(funcIn));
  ppcmf_pad_model ppcmf_pad_model_i (.mclk(mclk), .padOut(padOut), .padOe(padOe),
    .pullupOn(pullupOn), .extLevel(extLevel), .extOe(extOe), .padIn(padIn));
  // Clocks; the slow clock is ten system cycles to keep the run short
  always #25 mclk = ~mclk;
  always begin
    repeat (5) @(posedge mclk);
    slck <= ~slck;
  end
  //////////////////////////////////////////////////
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      testsRun = testsRun + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // One classic cycle; ack is read before the edge's own updates land
  task bus(input w, input [31:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datW <= d;
      sel <= s;
      n = 0;
      @(posedge mclk);
      while (ack !== 1'b1 && n < 40) begin
        n = n + 1;
        @(posedge mclk);
      end
      if (n >= 40) errors = errors + 1;
      rd = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task rc(input string name, input [31:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0, 4'hf);
      check(name, rd, exp);
    end
  endtask
  // Drive a pulse from outside and note whether it ever reached funcIn
  task pulse(input integer line, input integer width, input expSeen);
    integer n;
    reg seen;
    begin
      repeat (60) @(posedge mclk);
      seen = 1'b0;
      extLevel[line] <= 1'b1;
      for (n = 0; n < 150; n = n + 1) begin
        @(posedge mclk);
        if (n == width - 1) extLevel[line] <= 1'b0;
        seen = seen | funcIn[line];
      end
      check("funcIn", seen, expSeen);
    end
  endtask
  task reportAndStop;
    begin
      $display("checks %0d mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////
  // Watchdog far beyond the roughly 1200 cycles the tests need
  initial begin
    #(50 * 20000);
    errors = errors + 1;
    reportAndStop;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rc("mdStatus", `PPCMF_ADR_MULTIDRIVE_STATUS, 32'h0);
    rc("puStatus", `PPCMF_ADR_PULLUP_STATUS, 32'h0);
    rc("fcStatus", `PPCMF_ADR_FILTER_CLOCK_SELECT_STATUS, 32'h0);
    rc("divider", `PPCMF_ADR_DEBOUNCE_CLOCK_DIVIDER, 32'h0);
    wr(`PPCMF_ADR_MULTIDRIVE_ENABLE, 32'h000000ff);
    wr(`PPCMF_ADR_MULTIDRIVE_DISABLE, 32'h0000000f);
    bus(1'b1, `PPCMF_ADR_MULTIDRIVE_ENABLE, 32'hffffffff, 4'h4);
    rc("mdStatus", `PPCMF_ADR_MULTIDRIVE_STATUS, 32'h00ff00f0);
    wr(`PPCMF_ADR_PULLUP_DISABLE, 32'h000000f0);
    wr(`PPCMF_ADR_PULLUP_ENABLE, 32'h00000030);
    rc("puStatus", `PPCMF_ADR_PULLUP_STATUS, 32'h000000c0);
    check("pullupOn", pullupOn, 32'hffffff3f);
    // Each function code on all lines, push-pull
    wr(`PPCMF_ADR_MULTIDRIVE_DISABLE, 32'hffffffff);
    for (k = 0; k < 4; k = k + 1) begin
      wr(`PPCMF_ADR_PERIPHERAL_SELECT_LOW, k[0] ? 32'hffffffff : 32'h0);
      wr(`PPCMF_ADR_PERIPHERAL_SELECT_HIGH, k[1] ? 32'hffffffff : 32'h0);
      repeat (2) @(posedge mclk);
      check("padOut", padOut, 32'h11111111 << k);
      check("padOe", padOe, ~(32'h00000001 << k));
    end
    rc("selHigh", `PPCMF_ADR_PERIPHERAL_SELECT_HIGH, 32'hffffffff);
    // Open drain: low only, enabled where the function drives 0
    wr(`PPCMF_ADR_MULTIDRIVE_ENABLE, 32'hffffffff);
    repeat (2) @(posedge mclk);
    check("padOut", padOut, 32'h0);
    check("padOe", padOe, 32'h77777777);
    // Protected writes are acked but change nothing
    wr(`PPCMF_ADR_WRITE_PROTECT, 32'h1);
    wr(`PPCMF_ADR_PULLUP_ENABLE, 32'hffffffff);
    wr(`PPCMF_ADR_MULTIDRIVE_DISABLE, 32'hffffffff);
    wr(`PPCMF_ADR_PERIPHERAL_SELECT_LOW, 32'h0);
    rc("puStatus", `PPCMF_ADR_PULLUP_STATUS, 32'h000000c0);
    rc("mdStatus", `PPCMF_ADR_MULTIDRIVE_STATUS, 32'hffffffff);
    rc("selLow", `PPCMF_ADR_PERIPHERAL_SELECT_LOW, 32'hffffffff);
    rc("protect", `PPCMF_ADR_WRITE_PROTECT, 32'h00000001);
    wr(`PPCMF_ADR_WRITE_PROTECT, 32'h0);
    rc("unmapped", 32'h400e0e00, 32'h0);
    // Filter clock choice per line and divider field width
    wr(`PPCMF_ADR_FILTER_CLOCK_DEBOUNCE_SELECT, 32'h0000000f);
    wr(`PPCMF_ADR_FILTER_CLOCK_GLITCH_SELECT, 32'h00000003);
    rc("fcStatus", `PPCMF_ADR_FILTER_CLOCK_SELECT_STATUS, 32'h0000000c);
    wr(`PPCMF_ADR_DEBOUNCE_CLOCK_DIVIDER, 32'hffffffff);
    rc("divider", `PPCMF_ADR_DEBOUNCE_CLOCK_DIVIDER, 32'h00003fff);
    wr(`PPCMF_ADR_DEBOUNCE_CLOCK_DIVIDER, 32'h00000001);
    // Pads turn to inputs driven from outside; filters on lines 0 and 2
    fOe <= 32'h0;
    extOe <= 32'hffffffff;
    wr(`PPCMF_ADR_FILTER_ON, 32'h00000005);
    rc("filterOn", `PPCMF_ADR_FILTER_STATUS, 32'h00000005);
    pulse(0, 1, 1'b0); // Glitch line drops a one-cycle pulse
    pulse(1, 1, 1'b1); // Unfiltered line passes it
    pulse(2, 5, 1'b0); // Debounce line drops a short pulse
    pulse(2, 100, 1'b1); // Debounce line passes a long pulse
    // Filter switched off on line 0 only; line 2 keeps its filter
    wr(`PPCMF_ADR_FILTER_OFF, 32'h00000001);
    rc("filterOn", `PPCMF_ADR_FILTER_STATUS, 32'h00000004);
    pulse(0, 1, 1'b1); // Line 0 unfiltered again passes it
    reportAndStop;
  end
endmodule
